// file: inc/tqu_pkg.sv
package tqu_pkg;

   // Clocking
   localparam int SYS_CLK_HZ      = 10_000_000;
   localparam int MCLK_DIV        = 4;
   localparam int FLUSH_MCLK      = 80;
   localparam int FLUSH_CYC       = FLUSH_MCLK * MCLK_DIV;

   // Stream widths
   localparam int NIB_W           = 6;
   localparam int SAMP_W          = 12;
   localparam int SYM_W           = 2 * SAMP_W;
   localparam int NIBS_PER_SYM    = 4;
   localparam int FTW_W           = 26;
   localparam int FIFO_DEPTH      = 8;

   // Interpolation
   localparam int FIR_R           = 4;
   localparam int CIC_R           = 4;
   localparam int TOTAL_R         = FIR_R * CIC_R;
   localparam int CIC_W           = 16;
   localparam int LUT_W           = 6;

   // Nibble positions inside a symbol
   localparam logic [1:0] POS_I_HI = 2'h0;
   localparam logic [1:0] POS_I_LO = 2'h1;
   localparam logic [1:0] POS_Q_HI = 2'h2;
   localparam logic [1:0] POS_Q_LO = 2'h3;

   // Carrier phase offset of a quarter turn in the sine table
   localparam logic [LUT_W-1:0] QUARTER_TURN = 6'h10;

   // Inverse sinc taps: (-1, 18, -1) / 16
   localparam logic signed [5:0] ISINC_CENTER = 6'sh12;
   localparam int                ISINC_SHIFT  = 4;
   localparam int                MOD_SHIFT    = 11;

   typedef enum logic [1:0] {
      TQU_PWR_RUN   = 2'b00,
      TQU_PWR_DOWN  = 2'b01,
      TQU_PWR_FLUSH = 2'b10
   } tqu_pwr_t;

   // Quarter-wave sine, sampled at odd multiples of pi/64
   function automatic logic signed [SAMP_W-1:0] tqu_sine(input logic [LUT_W-1:0] ph);
      logic [3:0]        idx;
      logic [SAMP_W-1:0] mag;
      idx = ph[4] ? ~ph[3:0] : ph[3:0];
      unique case (idx)
         4'h0: mag = 12'h064;
         4'h1: mag = 12'h12C;
         4'h2: mag = 12'h1F1;
         4'h3: mag = 12'h2B2;
         4'h4: mag = 12'h36B;
         4'h5: mag = 12'h41C;
         4'h6: mag = 12'h4C3;
         4'h7: mag = 12'h55F;
         4'h8: mag = 12'h5ED;
         4'h9: mag = 12'h66C;
         4'hA: mag = 12'h6DC;
         4'hB: mag = 12'h73B;
         4'hC: mag = 12'h787;
         4'hD: mag = 12'h7C2;
         4'hE: mag = 12'h7E9;
         4'hF: mag = 12'h7FD;
      endcase
      return ph[5] ? -$signed(mag) : $signed(mag);
   endfunction

endpackage

// file: design/tqu_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module tqu_fifo #(
   parameter int W     = 24,
   parameter int DEPTH = 8
) (
   input  wire  logic         clk,
   input  wire  logic         rst,
   input  wire  logic         in_valid,
   output logic               in_ready,
   input  wire  logic [W-1:0] in_data,
   output logic               out_valid,
   input  wire  logic         out_ready,
   output logic [W-1:0]       out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0]   count_q;
   logic          push;
   logic          pop;

   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_q[rd_ptr_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule // tqu_fifo

`default_nettype wire

// file: design/tqu_tx_upconverter.sv
// Behaviour
// - I and Q are 12-bit words throughout
// - Four 6-bit nibbles build one symbol
// - At most one nibble captured per system clock
// - Sync high marks a symbol's first nibble
// - Nibbles one-two form I, three-four Q
// - Components are signed twos complement
// - 4x FIR then 4x CIC, total 16
// - Interpolators low-pass filter out images
// - Modulator shifts baseband to synthesized carrier
// - Synthesizer on system clock, 26-bit tuning
// - I times cosine carrier, less Q times sine
// - One 12-bit sample per clock out
// - Inverse sinc between modulator and output
// - Output path sustains one sample per clock
// - Power-down freezes datapath, resets CIC
// - CIC held reset 80 master cycles after
// - Software power-down acts like the pin
`timescale 1ns/1ps
`default_nettype none

module tqu_tx_upconverter
   import tqu_pkg::*;
#(
   parameter int FIFO_D   = FIFO_DEPTH,
   parameter int FLUSH_N  = FLUSH_CYC
) (
   input  wire  logic              SYS_CLK,
   input  wire  logic              RST,
   input  wire  logic [NIB_W-1:0]  TX_NIBBLE_BUS,
   input  wire  logic              TX_NIBBLE_VALID,
   input  wire  logic              TX_SYMBOL_STROBE,
   output logic                    TX_READY,
   input  wire  logic              TX_POWER_DOWN_N,
   input  wire  logic              TX_SW_POWER_DOWN,
   input  wire  logic [FTW_W-1:0]  TX_FREQ_WORD,
   output logic [SAMP_W-1:0]       DAC_DATA,
   output logic                    TX_ACTIVE
);

   // ---------------- Power-down control ----------------
   tqu_pwr_t             pwr_q;
   logic [8:0]           flush_cnt_q;
   logic                 pd_req;
   logic                 active;
   logic                 cic_clr;

   assign pd_req  = ~TX_POWER_DOWN_N | TX_SW_POWER_DOWN;
   assign active  = (pwr_q != TQU_PWR_DOWN);
   assign cic_clr = RST | (pwr_q != TQU_PWR_RUN);
   assign TX_ACTIVE = (pwr_q == TQU_PWR_RUN);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pwr_q       <= TQU_PWR_DOWN;
         flush_cnt_q <= '0;
      end else begin
         unique case (pwr_q)
            TQU_PWR_RUN: begin
               if (pd_req) begin
                  pwr_q <= TQU_PWR_DOWN;
               end
            end
            TQU_PWR_DOWN: begin
               if (!pd_req) begin
                  pwr_q       <= TQU_PWR_FLUSH;
                  flush_cnt_q <= 9'(FLUSH_N - 1);
               end
            end
            TQU_PWR_FLUSH: begin
               if (pd_req) begin
                  pwr_q <= TQU_PWR_DOWN;
               end else if (flush_cnt_q == '0) begin
                  pwr_q <= TQU_PWR_RUN;
               end else begin
                  flush_cnt_q <= flush_cnt_q - 1'b1;
               end
            end
            default: begin
               pwr_q <= TQU_PWR_DOWN;
            end
         endcase
      end
   end

   // ---------------- Symbol assembler ----------------
   logic [1:0]             pos_q;
   logic [NIB_W-1:0]       i_hi_q;
   logic [NIB_W-1:0]       i_lo_q;
   logic [NIB_W-1:0]       q_hi_q;
   logic                   take;
   logic                   push;
   logic                   fifo_in_ready;
   logic [SYM_W-1:0]       push_data;

   assign TX_READY  = fifo_in_ready & active;
   assign take      = TX_READY & TX_NIBBLE_VALID;
   // A symbol is pushed on its fourth nibble; a nibble at position zero without sync is dropped
   assign push      = take & ~TX_SYMBOL_STROBE & (pos_q == POS_Q_LO);
   assign push_data = {i_hi_q, i_lo_q, q_hi_q, TX_NIBBLE_BUS};

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pos_q  <= POS_I_HI;
         i_hi_q <= '0;
         i_lo_q <= '0;
         q_hi_q <= '0;
      end else if (take) begin
         if (TX_SYMBOL_STROBE) begin
            i_hi_q <= TX_NIBBLE_BUS;
            pos_q  <= POS_I_LO;
         end else begin
            unique case (pos_q)
               POS_I_HI: begin
                  pos_q <= POS_I_HI;
               end
               POS_I_LO: begin
                  i_lo_q <= TX_NIBBLE_BUS;
                  pos_q  <= POS_Q_HI;
               end
               POS_Q_HI: begin
                  q_hi_q <= TX_NIBBLE_BUS;
                  pos_q  <= POS_Q_LO;
               end
               POS_Q_LO: begin
                  pos_q <= POS_I_HI;
               end
            endcase
         end
      end
   end

   // ---------------- Symbol buffer ----------------
   logic                   fifo_out_valid;
   logic                   fifo_out_ready;
   logic [SYM_W-1:0]       fifo_out_data;

   tqu_fifo #(
      .W     (SYM_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst       (RST),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ---------------- Rate sequencing ----------------
   logic [3:0]             phase_q;
   logic                   sym_tick;
   logic                   fir_tick;
   logic signed [SAMP_W-1:0] sym_in [2];

   assign sym_tick       = active & (phase_q == '0);
   assign fir_tick       = active & (phase_q[1:0] == '0);
   assign fifo_out_ready = sym_tick;
   // An empty buffer feeds null symbols so the filters keep settling
   assign sym_in[0] = fifo_out_valid ? $signed(fifo_out_data[SYM_W-1:SAMP_W]) : '0;
   assign sym_in[1] = fifo_out_valid ? $signed(fifo_out_data[SAMP_W-1:0]) : '0;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         phase_q <= '0;
      end else if (active) begin
         phase_q <= (phase_q == 4'(TOTAL_R - 1)) ? '0 : phase_q + 1'b1;
      end
   end

   // ---------------- Interpolators, per channel ----------------
   logic signed [SAMP_W-1:0] cic_out [2];

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic signed [SAMP_W-1:0] x_prev_q;
      logic signed [SAMP_W-1:0] x_cur_q;
      logic signed [SAMP_W-1:0] fir_q;
      logic signed [3:0]        w_cur;
      logic signed [3:0]        w_prev;
      logic signed [16:0]       fir_acc;
      logic signed [13:0]       comb_x_d_q;
      logic signed [13:0]       comb1_d_q;
      logic signed [13:0]       comb1;
      logic signed [13:0]       comb2_q;
      logic signed [CIC_W-1:0]  integ_in;
      logic signed [CIC_W-1:0]  integ1_q;
      logic signed [CIC_W-1:0]  integ2_q;

      // Linear-phase 4x FIR: triangular polyphase weights
      assign w_cur   = $signed({2'b00, phase_q[3:2]});
      assign w_prev  = 4'(FIR_R) - w_cur;
      assign fir_acc = 17'(x_prev_q * w_prev) + 17'(x_cur_q * w_cur);

      always_ff @(posedge SYS_CLK) begin
         if (RST) begin
            x_prev_q <= '0;
            x_cur_q  <= '0;
            fir_q    <= '0;
         end else begin
            if (sym_tick) begin
               x_prev_q <= x_cur_q;
               x_cur_q  <= sym_in[ch];
            end
            if (fir_tick) begin
               fir_q <= fir_acc[13:2];
            end
         end
      end

      // Two-stage CIC, combs at the FIR rate, integrators every clock
      assign comb1    = 14'(fir_q) - comb_x_d_q;
      assign integ_in = fir_tick ? CIC_W'(comb2_q) : '0;

      always_ff @(posedge SYS_CLK) begin
         if (cic_clr) begin
            comb_x_d_q <= '0;
            comb1_d_q  <= '0;
            comb2_q    <= '0;
            integ1_q   <= '0;
            integ2_q   <= '0;
         end else if (active) begin
            if (fir_tick) begin
               comb_x_d_q <= 14'(fir_q);
               comb1_d_q  <= comb1;
               comb2_q    <= comb1 - comb1_d_q;
            end
            integ1_q <= integ1_q + integ_in;
            integ2_q <= integ2_q + integ1_q;
         end
      end

      // Gain of the CIC is CIC_R, removed by dropping two bits
      assign cic_out[ch] = integ2_q[13:2];
   end

   // ---------------- Carrier synthesizer ----------------
   logic [FTW_W-1:0]         acc_q;
   logic [LUT_W-1:0]         ph;
   logic signed [SAMP_W-1:0] carr_cos;
   logic signed [SAMP_W-1:0] carr_sin;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         acc_q <= '0;
      end else if (active) begin
         acc_q <= acc_q + TX_FREQ_WORD;
      end
   end

   assign ph       = acc_q[FTW_W-1 -: LUT_W];
   assign carr_sin = tqu_sine(ph);
   assign carr_cos = tqu_sine(ph + QUARTER_TURN);

   // ---------------- Quadrature modulator ----------------
   logic signed [23:0]       prod_i;
   logic signed [23:0]       prod_q;
   logic signed [24:0]       mod_sum;
   logic signed [13:0]       mod_q;

   assign prod_i  = cic_out[0] * carr_cos;
   assign prod_q  = cic_out[1] * carr_sin;
   assign mod_sum = 25'(prod_i) - 25'(prod_q);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         mod_q <= '0;
      end else if (active) begin
         mod_q <= mod_sum[MOD_SHIFT +: 14];
      end
   end

   // ---------------- Inverse sinc and output ----------------
   logic signed [13:0]       isinc_d1_q;
   logic signed [13:0]       isinc_d2_q;
   logic signed [20:0]       isinc_acc;
   logic signed [16:0]       isinc_scaled;

   function automatic logic signed [SAMP_W-1:0] sat_samp(input logic signed [16:0] v);
      logic signed [16:0] hi;
      logic signed [16:0] lo;
      hi = 17'sh007FF;
      lo = -17'sh00800;
      if (v > hi) begin
         return 12'h7FF;
      end else if (v < lo) begin
         return 12'h800;
      end else begin
         return v[SAMP_W-1:0];
      end
   endfunction

   assign isinc_acc    = 21'(isinc_d1_q * ISINC_CENTER) - 21'(mod_q) - 21'(isinc_d2_q);
   assign isinc_scaled = 17'(isinc_acc >>> ISINC_SHIFT);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         isinc_d1_q <= '0;
         isinc_d2_q <= '0;
      end else if (active) begin
         isinc_d1_q <= mod_q;
         isinc_d2_q <= isinc_d1_q;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         DAC_DATA <= '0;
      end else if (active) begin
         DAC_DATA <= sat_samp(isinc_scaled);
      end
   end

endmodule // tqu_tx_upconverter

`default_nettype wire

// file: bench/tqu_tx_upconverter_checker.sv
`timescale 1ns/1ps
`default_nettype none

module tqu_tx_upconverter_checker
   import tqu_pkg::*;
#(
   parameter int FLUSH_N = FLUSH_CYC
) (
   input wire logic              SYS_CLK,
   input wire logic              RST,
   input wire logic [NIB_W-1:0]  TX_NIBBLE_BUS,
   input wire logic              TX_NIBBLE_VALID,
   input wire logic              TX_SYMBOL_STROBE,
   input wire logic              TX_READY,
   input wire logic              TX_POWER_DOWN_N,
   input wire logic              TX_SW_POWER_DOWN,
   input wire logic [FTW_W-1:0]  TX_FREQ_WORD,
   input wire logic [SAMP_W-1:0] DAC_DATA,
   input wire logic              TX_ACTIVE
);
   logic        pd;
   logic [15:0] up_q;

   assign pd = !TX_POWER_DOWN_N || TX_SW_POWER_DOWN;

   // Edges spent short of RUN since power-down or reset was last seen
   always_ff @(posedge SYS_CLK) begin
      if (RST || pd) begin
         up_q <= 16'h0000;
      end else if (!TX_ACTIVE) begin
         up_q <= up_q + 16'h0001;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_reset_idle: assert property (disable iff (1'b0) RST |=> !TX_READY && !TX_ACTIVE)
      else $error("ready or active during reset");
   a_reset_dac: assert property (disable iff (1'b0) RST |=> DAC_DATA == 12'h000)
      else $error("output not zero during reset");
   a_pd_ready: assert property (pd |=> !TX_READY)
      else $error("ready while powered down");
   a_sw_pd_halt: assert property (TX_SW_POWER_DOWN |=> !TX_READY && !TX_ACTIVE)
      else $error("software power-down ignored");
   a_pin_pd_halt: assert property (!TX_POWER_DOWN_N |=> !TX_ACTIVE)
      else $error("active while pin power-down");
   a_dac_frozen: assert property (pd ##1 pd |=> $stable(DAC_DATA))
      else $error("output moved while powered down");
   a_flush_exact: assert property ($rose(TX_ACTIVE) |-> up_q == FLUSH_N + 1)
      else $error("flush length wrong");
   a_flush_bound: assert property (!TX_ACTIVE |-> up_q <= FLUSH_N)
      else $error("flush overran");
endmodule // tqu_tx_upconverter_checker

bind tqu_tx_upconverter tqu_tx_upconverter_checker #(.FLUSH_N(FLUSH_N)) u_tqu_checker (
   .SYS_CLK(SYS_CLK), .RST(RST), .TX_NIBBLE_BUS(TX_NIBBLE_BUS),
   .TX_NIBBLE_VALID(TX_NIBBLE_VALID), .TX_SYMBOL_STROBE(TX_SYMBOL_STROBE),
   .TX_READY(TX_READY), .TX_POWER_DOWN_N(TX_POWER_DOWN_N),
   .TX_SW_POWER_DOWN(TX_SW_POWER_DOWN), .TX_FREQ_WORD(TX_FREQ_WORD),
   .DAC_DATA(DAC_DATA), .TX_ACTIVE(TX_ACTIVE)
);

`default_nettype wire

// file: bench/tqu_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module tqu_host_model
   import tqu_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             go,
   input  wire logic [SYM_W-1:0] sym,
   input  wire logic [2:0]       nibs,
   input  wire logic             stb_first,
   input  wire logic             ready,
   output logic [NIB_W-1:0]      bus,
   output logic                  valid,
   output logic                  strobe
);
   logic [SYM_W-1:0] sym_q;
   logic [2:0]       idx_q;
   logic [2:0]       last_q;

   // Nibbles go out upper half first, I before Q, held until taken
   always_ff @(posedge clk) begin
      if (rst) begin
         valid <= 1'b0;
         strobe <= 1'b0;
         bus <= 6'h00;
         idx_q <= 3'h0;
      end else if (valid && ready) begin
         strobe <= 1'b0;
         if (idx_q == last_q) begin
            valid <= 1'b0;
            bus <= ~bus; // Released bus does not keep its last value
         end else begin
            idx_q <= idx_q + 3'h1;
            bus <= sym_q[SYM_W-1-NIB_W*(idx_q+1) -: NIB_W];
         end
      end else if (go && !valid) begin
         sym_q <= sym;
         last_q <= nibs - 3'h1;
         idx_q <= 3'h0;
         valid <= 1'b1;
         strobe <= stb_first;
         bus <= sym[SYM_W-1 -: NIB_W];
      end
   end
endmodule // tqu_host_model

`default_nettype wire

// file: bench/tqu_tx_upconverter_test.sv
`timescale 1ns/1ps
`default_nettype none

module tqu_tx_upconverter_test
   import tqu_pkg::*;
();
   localparam int FL = 8;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              pwr_n = 1'b1;
   logic              sw_pd = 1'b0;
   logic [FTW_W-1:0]  ftw = '0;
   logic              go = 1'b0;
   logic [SYM_W-1:0]  sym = '0;
   logic [2:0]        nibs = 3'h4;
   logic              stb = 1'b1;
   logic              stall = 1'b0;
   logic [NIB_W-1:0]  bus;
   logic              valid, strobe, ready, active;
   logic [SAMP_W-1:0] dac;
   int                num_errors = 0;
   int                total_checks = 0;

   always #50 clk = ~clk;

   tqu_tx_upconverter #(.FIFO_D(FIFO_DEPTH), .FLUSH_N(FL)) u_tqu_tx_upconverter (
      .SYS_CLK(clk), .RST(rst), .TX_NIBBLE_BUS(bus), .TX_NIBBLE_VALID(valid),
      .TX_SYMBOL_STROBE(strobe), .TX_READY(ready), .TX_POWER_DOWN_N(pwr_n),
      .TX_SW_POWER_DOWN(sw_pd), .TX_FREQ_WORD(ftw), .DAC_DATA(dac), .TX_ACTIVE(active));

   tqu_host_model u_tqu_host_model (
      .clk(clk), .rst(rst), .go(go), .sym(sym), .nibs(nibs), .stb_first(stb),
      .ready(ready), .bus(bus), .valid(valid), .strobe(strobe));

   // Buffer refusal seen while running
   always @(posedge clk) begin
      if (valid === 1'b1 && ready === 1'b0 && active === 1'b1) stall <= 1'b1;
   end

   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic want);
      total_checks++;
      if (got !== want) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, want);
      end
   endtask

   task automatic check_near(input logic [SAMP_W-1:0] got, input int want, input int tol);
      int d;
      d = $signed(got) - want;
      total_checks++;
      if ((^got) === 1'bx || d > tol || d < -tol) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, want[SAMP_W-1:0]);
      end
   endtask

   task automatic send(input logic [SYM_W-1:0] s, input logic [2:0] n, input logic st);
      int k;
      @(posedge clk);
      sym <= s;
      nibs <= n;
      stb <= st;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (valid === 1'b1 && k < 300);
      check_bit(valid, 1'b0);
   endtask

   task automatic dc_case(input logic [SAMP_W-1:0] i, input logic [SAMP_W-1:0] q);
      repeat (30) send({i, q}, 3'h4, 1'b1);
      check_near(dac, ($signed(i) * 2045 - $signed(q) * 100) / 2048, 24);
   endtask

   task automatic restart_case();
      repeat (30) begin
         send(24'h3F0000, 3'h1, 1'b0);
         send(24'h7FF7FF, 3'h2, 1'b1);
         send(24'h400000, 3'h4, 1'b1);
      end
      check_near(dac, 1022, 24);
   endtask

   task automatic pd_case(input logic use_sw);
      logic [SAMP_W-1:0] held;
      @(posedge clk);
      pwr_n <= use_sw;
      sw_pd <= use_sw;
      repeat (3) @(posedge clk);
      #1;
      held = dac;
      check_bit(ready, 1'b0);
      check_bit(active, 1'b0);
      repeat (5) @(posedge clk);
      #1;
      check_near(dac, $signed(held), 0);
      @(posedge clk);
      pwr_n <= 1'b1;
      sw_pd <= 1'b0;
      repeat (FL - 2) @(posedge clk);
      #1;
      check_bit(active, 1'b0);
      repeat (5) @(posedge clk);
      #1;
      check_bit(active, 1'b1);
   endtask

   task automatic carrier_case();
      int hi;
      int lo;
      int y0;
      int amp;
      hi = -4096;
      lo = 4096;
      @(posedge clk);
      ftw <= 26'h0200000;
      repeat (20) send(24'h400000, 3'h4, 1'b1);
      repeat (64) begin
         @(posedge clk);
         #1;
         if ($signed(dac) > hi) hi = $signed(dac);
         if ($signed(dac) < lo) lo = $signed(dac);
      end
      check_near(hi[SAMP_W-1:0], 1023, 96);
      check_near(lo[SAMP_W-1:0], -1023, 96);
      // Quarter-rate carrier: compensation lifts it by 18/16, two samples give squared amplitude over 1024
      @(posedge clk);
      ftw <= 26'h1000000;
      repeat (10) send(24'h400000, 3'h4, 1'b1);
      @(posedge clk);
      #1;
      y0 = $signed(dac);
      @(posedge clk);
      #1;
      amp = (y0 * y0 + $signed(dac) * $signed(dac)) >>> 10;
      check_near(amp[SAMP_W-1:0], 1296, 48);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      check_bit(ready, 1'b0);
      check_near(dac, 0, 0);
      repeat (FL + 4) @(posedge clk);
      #1;
      check_bit(active, 1'b1);
      dc_case(12'h400, 12'h000);
      check_bit(stall, 1'b1);
      dc_case(12'h000, 12'h400);
      dc_case(12'hC00, 12'h000);
      repeat (400) @(posedge clk);
      #1;
      check_near(dac, 0, 4);
      restart_case();
      pd_case(1'b0);
      pd_case(1'b1);
      carrier_case();
      results();
   end

   initial begin
      #4_000_000;
      num_errors++;
      results();
   end
endmodule // tqu_tx_upconverter_test

`default_nettype wire
